// file: core/hbc_pkg.sv
/*
 * Constants and types shared by the host bus command and status port.
 * Assumes a single 125 MHz system clock and a synchronous active-high reset.
 */
// Notes on behaviour
// - Command 0xFD04 sets configuration, wait output high.
// - Command 0xFD06 sets configuration, wait output low.
// - Status reads 0x0002 after reset, interrupt high.
// - Eight-bit mode pairs two reads per word.
// - Command 0xFEzz loads page, shown in upper byte.
// - Command 0x8801 returns clock B, then clock A.
// - Missing clock or frame sync reads 0x92FB.
// - Interrupt output low while any interrupt pending.
package hbc_pkg;
    localparam logic [7:0] OP_CODE_CFG = 8'hfd;
    localparam logic [7:0] OP_CODE_PAGE = 8'hfe;
    localparam logic [15:0] CMD_CFG_WAIT_HIGH = 16'hfd04;
    localparam logic [15:0] CMD_CFG_WAIT_LOW = 16'hfd06;
    localparam logic [15:0] CMD_READ_PCM_RATES = 16'h8801;
    localparam logic [7:0] CFG_RESET = 8'h04;
    localparam int CFG_WAIT_LOW_BIT = 1;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [15:0] STATUS_RESET = 16'h0002;
    localparam int STATUS_INT_BIT = 1;
    localparam logic [15:0] RATE_ABSENT = 16'h92fb;
    localparam logic [15:0] DATA_NONE = 16'h0000;
    localparam logic ADDR_STATUS = 1'b0;
    localparam logic ADDR_DATA = 1'b1;
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int PCM_CLK_LOSS_NS = 4000;
    localparam int FS_LOSS_NS = 250000;
    localparam int PCM_CLK_LOSS_CYCLES = (PCM_CLK_LOSS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int FS_LOSS_CYCLES = (FS_LOSS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {
        OP_CFG = 2'b00,
        OP_PAGE = 2'b01,
        OP_READ = 2'b10
    } hbc_op_type;
endpackage : hbc_pkg

// file: core/hbc_clock_meter.sv
/*
 * Measures one PCM bit clock as its count of rising edges per frame sync period.
 * Assumes the clock and frame sync come from pins, asynchronous to clock_in.
 */
`timescale 1ns/1ps
module hbc_clock_meter import hbc_pkg::*; #(
    parameter int CLK_LOSS = PCM_CLK_LOSS_CYCLES,
    parameter int FS_LOSS = FS_LOSS_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic pcm_clock_in,
    input wire logic frame_sync_in,
    output logic [15:0] rate_out
);
    logic [2:0] clk_sync;
    logic [2:0] fs_sync;
    logic [15:0] clk_age;
    logic [15:0] fs_age;
    logic [15:0] edge_count;
    wire clk_rise = clk_sync[1] & ~clk_sync[2];
    wire fs_rise = fs_sync[1] & ~fs_sync[2];
    wire present = (clk_age < 16'(CLK_LOSS)) && (fs_age < 16'(FS_LOSS));

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            clk_sync <= 3'h0;
            fs_sync <= 3'h0;
        end else begin
            clk_sync <= {clk_sync[1:0], pcm_clock_in};
            fs_sync <= {fs_sync[1:0], frame_sync_in};
        end
    end

    // Ages saturate so a dead clock stays absent without wrapping back to present.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            clk_age <= 16'hffff;
            fs_age <= 16'hffff;
            edge_count <= 16'h0000;
            rate_out <= RATE_ABSENT;
        end else begin
            clk_age <= clk_rise ? 16'h0000 : (clk_age == 16'hffff ? clk_age : clk_age + 16'h0001);
            fs_age <= fs_rise ? 16'h0000 : (fs_age == 16'hffff ? fs_age : fs_age + 16'h0001);
            if (fs_rise) begin
                edge_count <= {15'h0000, clk_rise};
            end else if (clk_rise && edge_count != 16'hffff) begin
                edge_count <= edge_count + 16'h0001;
            end
            if (!present) begin
                rate_out <= RATE_ABSENT;
            end else if (fs_rise) begin
                rate_out <= edge_count;
            end
        end
    end

    property p_absent_value;
        @(posedge clock_in) disable iff (rst_in) !present |=> (rate_out == RATE_ABSENT);
    endproperty
    a_absent_value: assert property (p_absent_value) else $error("rate not absent value");

    property p_rate_on_frame;
        @(posedge clock_in) disable iff (rst_in)
            (present && fs_rise) |=> (rate_out == $past(edge_count));
    endproperty
    a_rate_on_frame: assert property (p_rate_on_frame) else $error("rate not captured");
endmodule : hbc_clock_meter

// file: core/hbc_host_port.sv
/*
 * Parallel host bus port: command decode, status word, page and wait configuration,
 * and PCM clock rate readback.
 * Assumes host strobes are asynchronous and each stays active for at least four
 * clock_in periods, with data stable while the write strobe is active.
 */
`timescale 1ns/1ps
module hbc_host_port import hbc_pkg::*; #(
    parameter int FS_LOSS = FS_LOSS_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic bus_8bit_in,
    input wire logic host_cs_n_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic host_addr_in,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe_out,
    output logic host_wait_out,
    output logic host_int_out,
    input wire logic irq_pending_in,
    input wire logic pcm_clock_a_in,
    input wire logic pcm_clock_b_in,
    input wire logic frame_sync_in,
    output logic bus_8bit_out
);
    logic [1:0] s_cs_n;
    logic [1:0] s_rd_n;
    logic [1:0] s_wr_n;
    logic [1:0] s_addr;
    logic [1:0] s_wide;
    logic [15:0] s_data [2];
    logic wr_prev;
    logic rd_prev;
    logic [15:0] wr_hold;
    logic addr_hold;
    logic strap_taken;
    logic byte_hi;
    logic last_addr;
    logic [7:0] upper_byte;
    logic [7:0] cfg;
    logic [7:0] page;
    logic [15:0] rd_cmd;
    logic data_idx;
    logic [15:0] rate_a;
    logic [15:0] rate_b;

    function automatic logic [15:0] pick_half(input logic [15:0] word, input logic wide,
                                              input logic hi);
        if (wide) begin
            pick_half = word;
        end else begin
            pick_half = hi ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
        end
    endfunction : pick_half

    wire wr_act = ~s_cs_n[1] & ~s_wr_n[1];
    wire rd_act = ~s_cs_n[1] & ~s_rd_n[1];
    wire wr_done = wr_prev & ~wr_act;
    wire rd_start = rd_act & ~rd_prev;
    wire rd_done = rd_prev & ~rd_act;
    wire acc_addr = wr_done ? addr_hold : s_addr[1];
    wire phase_hi = byte_hi && (acc_addr == last_addr);
    // In 8-bit mode a word is complete only on the second byte of a pair.
    wire word_end = !bus_8bit_out || phase_hi;
    wire cmd_exec = wr_done && addr_hold == ADDR_STATUS && word_end;
    wire [15:0] cmd_word = bus_8bit_out ? {upper_byte, wr_hold[7:0]} : wr_hold;
    wire [15:0] status_word = {page, 6'h00, host_int_out, 1'b0};
    wire [15:0] data_word = (rd_cmd == CMD_READ_PCM_RATES) ? (data_idx ? rate_a : rate_b)
                                                            : DATA_NONE;
    wire [15:0] rd_word = (s_addr[1] == ADDR_STATUS) ? status_word : data_word;
    wire hbc_op_type op = (cmd_word[15:8] == OP_CODE_CFG) ? OP_CFG :
                          (cmd_word[15:8] == OP_CODE_PAGE) ? OP_PAGE : OP_READ;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_cs_n <= 2'h3;
            s_rd_n <= 2'h3;
            s_wr_n <= 2'h3;
            s_addr <= 2'h0;
            s_data[0] <= 16'h0000;
            s_data[1] <= 16'h0000;
        end else begin
            s_cs_n <= {s_cs_n[0], host_cs_n_in};
            s_rd_n <= {s_rd_n[0], host_rd_n_in};
            s_wr_n <= {s_wr_n[0], host_wr_n_in};
            s_addr <= {s_addr[0], host_addr_in};
            s_data[0] <= host_data_in;
            s_data[1] <= s_data[0];
        end
    end

    // The strap synchroniser keeps running in reset, so the pin level held before
    // release has already crossed it when the strap is caught.
    always_ff @(posedge clock_in) begin
        s_wide <= {s_wide[0], ~bus_8bit_in};
    end

    // The width strap is caught after reset release, once it has crossed the synchroniser.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            strap_taken <= 1'b0;
            bus_8bit_out <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            bus_8bit_out <= ~s_wide[1];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wr_prev <= 1'b0;
            rd_prev <= 1'b0;
            wr_hold <= 16'h0000;
            addr_hold <= ADDR_STATUS;
        end else begin
            wr_prev <= wr_act;
            rd_prev <= rd_act;
            if (wr_act) begin
                wr_hold <= s_data[1];
                addr_hold <= s_addr[1];
            end
        end
    end

    // Byte pairing: in 8-bit mode the high byte goes first; any access to the other
    // location restarts the pair, so a stray single byte cannot shift later words.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            byte_hi <= 1'b0;
            last_addr <= ADDR_STATUS;
            upper_byte <= 8'h00;
        end else if (wr_done || rd_done) begin
            last_addr <= acc_addr;
            byte_hi <= bus_8bit_out && !phase_hi;
            if (wr_done && !phase_hi) begin
                upper_byte <= wr_hold[7:0];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cfg <= CFG_RESET;
            page <= PAGE_RESET;
            rd_cmd <= 16'h0000;
        end else if (cmd_exec) begin
            case (op)
                OP_CFG: cfg <= cmd_word[7:0];
                OP_PAGE: page <= cmd_word[7:0];
                OP_READ: rd_cmd <= cmd_word;
                default: rd_cmd <= rd_cmd;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            data_idx <= 1'b0;
        end else if (cmd_exec && op == OP_READ) begin
            data_idx <= 1'b0;
        end else if (rd_done && s_addr[1] == ADDR_DATA && word_end) begin
            data_idx <= ~data_idx;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            host_data_out <= 16'h0000;
            host_data_oe_out <= 1'b0;
            host_wait_out <= 1'b1;
            host_int_out <= 1'b1;
        end else begin
            host_data_oe_out <= rd_act;
            if (rd_start) begin
                host_data_out <= pick_half(rd_word, !bus_8bit_out, phase_hi == 1'b0);
            end
            host_wait_out <= ~cfg[CFG_WAIT_LOW_BIT];
            host_int_out <= ~irq_pending_in;
        end
    end

    hbc_clock_meter #(.CLK_LOSS(PCM_CLK_LOSS_CYCLES), .FS_LOSS(FS_LOSS)) u_meter_a (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .pcm_clock_in(pcm_clock_a_in),
        .frame_sync_in(frame_sync_in),
        .rate_out(rate_a)
    );

    hbc_clock_meter #(.CLK_LOSS(PCM_CLK_LOSS_CYCLES), .FS_LOSS(FS_LOSS)) u_meter_b (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .pcm_clock_in(pcm_clock_b_in),
        .frame_sync_in(frame_sync_in),
        .rate_out(rate_b)
    );

    property p_wait_high;
        @(posedge clock_in) disable iff (rst_in)
            (cmd_exec && cmd_word == CMD_CFG_WAIT_HIGH) |=> ##1 host_wait_out;
    endproperty
    a_wait_high: assert property (p_wait_high) else $error("wait not high");

    property p_wait_low;
        @(posedge clock_in) disable iff (rst_in)
            (cmd_exec && cmd_word == CMD_CFG_WAIT_LOW) |=> ##1 !host_wait_out;
    endproperty
    a_wait_low: assert property (p_wait_low) else $error("wait not low");

    property p_reset_status;
        @(posedge clock_in) rst_in |=> (status_word == STATUS_RESET);
    endproperty
    a_reset_status: assert property (p_reset_status) else $error("bad reset status");

    sequence s_first_byte;
        bus_8bit_out && rd_done && !phase_hi;
    endsequence
    sequence s_second_ready;
        byte_hi && last_addr == $past(s_addr[1]);
    endsequence
    property p_byte_pair;
        @(posedge clock_in) disable iff (rst_in) s_first_byte |=> s_second_ready;
    endproperty
    a_byte_pair: assert property (p_byte_pair) else $error("byte pair lost");

    property p_page_load;
        @(posedge clock_in) disable iff (rst_in)
            (cmd_exec && op == OP_PAGE) |=> (status_word[15:8] == $past(cmd_word[7:0]));
    endproperty
    a_page_load: assert property (p_page_load) else $error("page not loaded");

    property p_word_zero_b;
        @(posedge clock_in) disable iff (rst_in)
            (rd_start && !bus_8bit_out && s_addr[1] == ADDR_DATA
             && rd_cmd == CMD_READ_PCM_RATES && !data_idx) |=> (host_data_out == $past(rate_b));
    endproperty
    a_word_zero_b: assert property (p_word_zero_b) else $error("word zero not clock B");

    property p_int_level;
        @(posedge clock_in) disable iff (rst_in) ##1 (host_int_out == !$past(irq_pending_in));
    endproperty
    a_int_level: assert property (p_int_level) else $error("interrupt level wrong");

    property p_decode_read;
        @(posedge clock_in) disable iff (rst_in)
            (cmd_exec && cmd_word[15:8] != OP_CODE_CFG && cmd_word[15:8] != OP_CODE_PAGE)
            |=> (rd_cmd == $past(cmd_word) && !data_idx);
    endproperty
    a_decode_read: assert property (p_decode_read) else $error("read command not decoded");
endmodule : hbc_host_port

// file: verification/hbc_host_model.sv
/*
 * Behavioural host controller that drives the parallel host bus port.
 * Assumes the bench calls its word tasks one at a time; strobes start at falling edges.
 */
`timescale 1ns/1ps
module hbc_host_model (
    input wire logic clock_in,
    input wire logic mode_8bit_in,
    input wire logic [15:0] rd_data_in,
    input wire logic oe_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic addr_out,
    output logic [15:0] wr_data_out
);
    // Six cycles active and idle gives margin over the four the port needs.
    localparam int HOLD = 6;
    logic oe_seen;

    initial begin
        oe_seen = 1'b0;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = 1'b0;
        wr_data_out = 16'h0000;
    end

    task automatic access(input logic wr, input logic addr, input logic [15:0] val,
                          output logic [15:0] got);
        @(negedge clock_in);
        cs_n_out = 1'b0;
        rd_n_out = wr;
        wr_n_out = ~wr;
        addr_out = addr;
        wr_data_out = val;
        repeat (HOLD) @(posedge clock_in);
        @(negedge clock_in);
        got = rd_data_in;
        oe_seen = oe_in;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        // A released bus must not keep showing the last value.
        wr_data_out = ~val;
        // Ending on a falling edge keeps the bench's following stimulus off the sampling edge.
        repeat (HOLD) @(negedge clock_in);
    endtask : access

    task automatic write_word(input logic addr, input logic [15:0] val);
        logic [15:0] unused;
        if (mode_8bit_in) begin
            access(1'b1, addr, {8'h00, val[15:8]}, unused);
            access(1'b1, addr, {8'h00, val[7:0]}, unused);
        end else begin
            access(1'b1, addr, val, unused);
        end
    endtask : write_word

    task automatic read_word(input logic addr, output logic [15:0] val);
        logic [15:0] hi;
        logic [15:0] lo;
        if (mode_8bit_in) begin
            access(1'b0, addr, 16'h0000, hi);
            access(1'b0, addr, 16'h0000, lo);
            val = {hi[7:0], lo[7:0]};
        end else begin
            access(1'b0, addr, 16'h0000, val);
        end
    endtask : read_word
endmodule : hbc_host_model

// file: verification/tb_top.sv
/*
 * Self-checking bench for the host bus port, run once in 8-bit and once in 16-bit mode.
 * Assumes the host model above; PCM clocks come from one tick loop stepped every
 * fourth falling clock edge.
 */
`timescale 1ns/1ps
module tb_top;
    import hbc_pkg::*;
    localparam int FS_LOSS_SIM = 400;
    localparam int LIMIT = 20000;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic bus_8bit_in = 1'b1;
    logic irq_pending_in = 1'b0;
    logic pcm_clock_a_in = 1'b0;
    logic pcm_clock_b_in = 1'b0;
    logic frame_sync_in = 1'b0;
    logic pcm_on = 1'b0;
    logic a_on = 1'b1;
    logic host_cs_n_in;
    logic host_rd_n_in;
    logic host_wr_n_in;
    logic host_addr_in;
    logic [15:0] host_data_in;
    logic [15:0] host_data_out;
    logic host_data_oe_out;
    logic host_wait_out;
    logic host_int_out;
    logic bus_8bit_out;
    int tick = 0;
    int cycles = 0;
    int fails = 0;
    int checks = 0;

    hbc_host_port #(.FS_LOSS(FS_LOSS_SIM)) i_hbc_host_port (
        .clock_in(clock_in), .rst_in(rst_in), .bus_8bit_in(bus_8bit_in),
        .host_cs_n_in(host_cs_n_in), .host_rd_n_in(host_rd_n_in),
        .host_wr_n_in(host_wr_n_in), .host_addr_in(host_addr_in),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe_out(host_data_oe_out), .host_wait_out(host_wait_out),
        .host_int_out(host_int_out), .irq_pending_in(irq_pending_in),
        .pcm_clock_a_in(pcm_clock_a_in), .pcm_clock_b_in(pcm_clock_b_in),
        .frame_sync_in(frame_sync_in), .bus_8bit_out(bus_8bit_out));

    hbc_host_model host (
        .clock_in(clock_in), .mode_8bit_in(bus_8bit_in), .rd_data_in(host_data_out),
        .oe_in(host_data_oe_out),
        .cs_n_out(host_cs_n_in), .rd_n_out(host_rd_n_in), .wr_n_out(host_wr_n_in),
        .addr_out(host_addr_in), .wr_data_out(host_data_in));

    initial forever #4 clock_in = ~clock_in;

    // Frame sync rises on ticks where neither bit clock rises, so each frame counts
    // exactly 32 edges of clock B and 16 of clock A despite synchroniser jitter.
    initial forever begin
        repeat (4) @(negedge clock_in);
        tick++;
        pcm_clock_b_in = pcm_on & tick[0];
        pcm_clock_a_in = pcm_on & a_on & tick[1];
        frame_sync_in = pcm_on & (tick % 64 == 0);
    end

    task automatic wrap_up();
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            wrap_up();
        end
    end

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : check16

    task automatic check1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t pin %b expected %b", $time, got, exp);
        end
    endtask : check1

    task automatic expect_read(input logic addr, input logic [15:0] exp);
        logic [15:0] got;
        host.read_word(addr, got);
        check16(got, exp);
        check1(host.oe_seen, 1'b1);
    endtask : expect_read

    task automatic rates(input logic [15:0] b_exp, input logic [15:0] a_exp);
        host.write_word(ADDR_STATUS, CMD_READ_PCM_RATES);
        expect_read(ADDR_DATA, b_exp);
        expect_read(ADDR_DATA, a_exp);
    endtask : rates

    initial begin
        for (int m = 1; m >= 0; m--) begin
            @(negedge clock_in);
            pcm_on = 1'b0;
            a_on = 1'b1;
            bus_8bit_in = m[0];
            rst_in = 1'b1;
            repeat (8) @(negedge clock_in);
            rst_in = 1'b0;
            repeat (4) @(negedge clock_in);
            check1(bus_8bit_out, m[0]);
            check1(host_wait_out, 1'b1);
            expect_read(ADDR_STATUS, STATUS_RESET);
            host.write_word(ADDR_STATUS, CMD_CFG_WAIT_LOW);
            check1(host_wait_out, 1'b0);
            host.write_word(ADDR_STATUS, CMD_CFG_WAIT_HIGH);
            check1(host_wait_out, 1'b1);
            host.write_word(ADDR_STATUS, 16'hfeaa);
            expect_read(ADDR_STATUS, 16'haa02);
            host.write_word(ADDR_STATUS, 16'hfeff);
            irq_pending_in = 1'b1;
            repeat (4) @(negedge clock_in);
            check1(host_int_out, 1'b0);
            expect_read(ADDR_STATUS, 16'hff00);
            irq_pending_in = 1'b0;
            repeat (4) @(negedge clock_in);
            check1(host_int_out, 1'b1);
            check1(host_data_oe_out, 1'b0);
            rates(RATE_ABSENT, RATE_ABSENT);
            pcm_on = 1'b1;
            repeat (1500) @(negedge clock_in);
            rates(16'h0020, 16'h0010);
            a_on = 1'b0;
            repeat (800) @(negedge clock_in);
            rates(16'h0020, RATE_ABSENT);
            host.write_word(ADDR_STATUS, 16'h1234);
            expect_read(ADDR_DATA, DATA_NONE);
            expect_read(ADDR_STATUS, 16'hff02);
        end
        wrap_up();
    end
endmodule : tb_top
